// ### logic/ppc_port.sv
// Functional notes
// - Port sits in exactly one of four hardware modes at a time.
// - Pin roles depend on selected hardware mode and protocol in use.
// - Compatibility and nibble protocols share identical pin hardware behaviour.
// - Data pin index equals protocol data line number minus one.
// - Pins without a role in a protocol stay functionally unused.
// - Data strobe output follows control register so software pulses it.
// - Busy input level is reflected in the status register.
// - Acknowledge input level is reported in the status register.
// - Online select input state is readable in the status register.
// - Paper error input level is reported in the status register.
// - Active-low fault input state is shown in the status register.
// - Active-low initialise output driven from a control register bit.
// - Active-low auto linefeed output driven from a control register bit.
// - Active-low peripheral select output driven from a control register bit.
`timescale 1ns/1ns
`default_nettype none
`include "ppc_cfg.svh"
module ppc_port
  import ppc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic strobe_n,
  output logic auto_linefeed_n,
  output logic init_n,
  output logic peripheral_select_n,
  output logic [7:0] port_data,
  output logic port_data_oe,
  input wire logic [7:0] port_data_in,
  input wire logic busy_in,
  input wire logic ack_n,
  input wire logic select_in,
  input wire logic paper_error_in,
  input wire logic fault_n
);

  ppc_state_t cur;
  ppc_state_t next_cur;

  // Word-aligned register offset of a byte address
  function automatic logic [11:0] ppc_word(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'b00};
    return w;
  endfunction : ppc_word

  // Address phase accepted: selected, ready and a non-idle, non-busy transfer (htrans bit 1 set)
  function automatic logic ppc_taken(
    input logic sel,
    input logic rdy,
    input logic [1:0] trans
  );
    logic t;
    t = sel & rdy & trans[1];
    return t;
  endfunction : ppc_taken

  // Status byte from live pin levels; unused positions read zero
  function automatic logic [7:0] ppc_status(
    input logic busy,
    input logic ack_lvl,
    input logic online,
    input logic paper,
    input logic fault_lvl
  );
    logic [7:0] s;
    s = 8'h00;
    // Busy inverted so a set bit means ready, as on the classic port
    s[`PPC_ST_BUSY] = ~busy;
    s[`PPC_ST_ACK] = ack_lvl;
    s[`PPC_ST_PAPER_ERROR_IN] = paper;
    s[`PPC_ST_SELECT] = online;
    s[`PPC_ST_FAULT] = fault_lvl;
    return s;
  endfunction : ppc_status

  // Read mux, evaluated at the address phase
  function automatic logic [31:0] ppc_read(
    input ppc_state_t s,
    input logic [11:0] a,
    input logic [7:0] pins
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      `PPC_ADDR_DATA: begin
        // Driven byte when outputs on, else the level seen on the pins
        r[7:0] = s.port_data_oe ? s.data_out : pins;
      end
      `PPC_ADDR_STATUS: begin
        r[7:0] = s.status;
      end
      `PPC_ADDR_CONTROL: begin
        r[7:0] = s.control;
      end
      `PPC_ADDR_MODE: begin
        r[`PPC_MODE_W-1:0] = s.mode;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction : ppc_read

  // Register write at the data phase; unmapped and read-only offsets dropped
  function automatic ppc_state_t ppc_write(
    input ppc_state_t s,
    input logic [11:0] a,
    input logic [31:0] d
  );
    ppc_state_t n;
    n = s;
    unique case (a)
      `PPC_ADDR_DATA: begin
        n.data_out = d[7:0];
      end
      `PPC_ADDR_CONTROL: begin
        n.control = d[7:0];
      end
      `PPC_ADDR_MODE: begin
        // Every two-bit code names one of the four modes, none illegal
        n.mode = ppc_mode_t'(d[`PPC_MODE_W-1:0]);
      end
      default: begin
        n = s;
      end
    endcase
    return n;
  endfunction : ppc_write

  // Output enable of the data pins: forced on in the first mode
  function automatic logic ppc_drive(
    input ppc_mode_t m,
    input logic [7:0] c
  );
    logic en;
    // Direction bit only counts once a bidirectional mode is set
    if (m == PPC_MODE_ISA) begin
      en = 1'b1;
    end else begin
      en = ~c[`PPC_CTL_DIR];
    end
    return en;
  endfunction : ppc_drive

  // Control pins straight from register bits, no generated timing
  function automatic ppc_state_t ppc_pins(input ppc_state_t s);
    ppc_state_t n;
    n = s;
    n.strobe_n = ~s.control[`PPC_CTL_STROBE];
    n.auto_linefeed_n = ~s.control[`PPC_CTL_AUTO_LINEFEED_N];
    // Clear bit holds the peripheral in reset, as after power-up
    n.init_n = s.control[`PPC_CTL_INIT];
    n.peripheral_select_n = ~s.control[`PPC_CTL_SELIN];
    n.port_data_oe = ppc_drive(s.mode, s.control);
    // Bit i carries protocol line i+1; parked low while released
    if (n.port_data_oe) begin
      n.port_data = s.data_out;
    end else begin
      n.port_data = 8'h00;
    end
    return n;
  endfunction : ppc_pins

  // Whole-state next value
  always_comb begin
    next_cur = cur;
    // Status is one flop behind the pins
    next_cur.status = ppc_status(busy_in, ack_n, select_in, paper_error_in, fault_n);
    // Zero wait states: every transfer completes in one data phase
    next_cur.hreadyout = 1'b1;
    next_cur.phase = PPC_PH_IDLE;
    // Write lands at the end of its data phase
    if (cur.phase == PPC_PH_DATA && cur.pend_write) begin
      next_cur = ppc_write(next_cur, cur.pend_addr, hwdata);
    end
    // Address phase captured for the following data phase
    if (ppc_taken(hsel, hready, htrans)) begin
      next_cur.phase = PPC_PH_DATA;
      next_cur.pend_write = hwrite;
      next_cur.pend_addr = ppc_word(haddr);
      // Read data loaded here so hrdata comes from a flop
      if (hwrite) begin
        next_cur.hrdata = 32'h0000_0000;
      end else begin
        next_cur.hrdata = ppc_read(cur, ppc_word(haddr), port_data_in);
      end
    end
    // Pins follow the register values that take effect at this edge
    next_cur = ppc_pins(next_cur);
  end

  // State register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur <= '{phase: PPC_PH_IDLE, pend_write: 1'b0, pend_addr: 12'h000,
               hreadyout: 1'b1, hrdata: 32'h0000_0000, data_out: 8'h00,
               control: `PPC_CTL_RESET, mode: PPC_MODE_ISA, status: 8'h00,
               strobe_n: 1'b1, auto_linefeed_n: 1'b1, init_n: 1'b0,
               peripheral_select_n: 1'b1, port_data: 8'h00, port_data_oe: 1'b1};
    end else if (clk_en) begin
      cur <= next_cur;
    end
  end

  assign hreadyout = cur.hreadyout;
  assign hresp = 1'b0;
  assign hrdata = cur.hrdata;
  assign strobe_n = cur.strobe_n;
  assign auto_linefeed_n = cur.auto_linefeed_n;
  assign init_n = cur.init_n;
  assign peripheral_select_n = cur.peripheral_select_n;
  assign port_data = cur.port_data;
  assign port_data_oe = cur.port_data_oe;

endmodule : ppc_port
`default_nettype wire

// ### logic/ppc_cfg.svh
`ifndef PPC_CFG_SVH
`define PPC_CFG_SVH
// Register byte addresses (word aligned)
`define PPC_ADDR_DATA 12'h000
`define PPC_ADDR_STATUS 12'h004
`define PPC_ADDR_CONTROL 12'h008
`define PPC_ADDR_MODE 12'h00C
// Control register field positions
`define PPC_CTL_STROBE 0
`define PPC_CTL_AUTO_LINEFEED_N 1
`define PPC_CTL_INIT 2
`define PPC_CTL_SELIN 3
`define PPC_CTL_DIR 5
// Control reset value: init asserted, others negated
`define PPC_CTL_RESET 8'h00
// Status register field positions
`define PPC_ST_FAULT 3
`define PPC_ST_SELECT 4
`define PPC_ST_PAPER_ERROR_IN 5
`define PPC_ST_ACK 6
`define PPC_ST_BUSY 7
// Mode field width and reset mode
`define PPC_MODE_W 2
`define PPC_MODE_RESET 2'h0
`endif

// ### logic/ppc_pkg.sv
package ppc_pkg;
  // Hardware mode of the port
  typedef enum logic [1:0] {
    PPC_MODE_ISA = 2'h0,
    PPC_MODE_BIDIR = 2'h1,
    PPC_MODE_EPP = 2'h2,
    PPC_MODE_ECP = 2'h3
  } ppc_mode_t;

  // Bus slave phase, one-hot
  typedef enum logic [1:0] {
    PPC_PH_IDLE = 2'b01,
    PPC_PH_DATA = 2'b10
  } ppc_phase_t;

  typedef struct packed {
    ppc_phase_t phase;
    logic pend_write;
    logic [11:0] pend_addr;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [7:0] data_out;
    logic [7:0] control;
    ppc_mode_t mode;
    logic [7:0] status;
    logic strobe_n;
    logic auto_linefeed_n;
    logic init_n;
    logic peripheral_select_n;
    logic [7:0] port_data;
    logic port_data_oe;
  } ppc_state_t;
endpackage : ppc_pkg

// ### sim/ppc_port_checker.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_chk (
  input wire logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic [31:0] hwdata,
  input wire logic strobe_n, auto_linefeed_n, init_n, peripheral_select_n, port_data_oe,
  input wire logic [7:0] port_data
);
  // Control write taken; pins follow two edges later
  wire logic cw = clk_en && hsel && hready && htrans[1] && hwrite && haddr == 12'h008;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_RDY: assert property (hreadyout) else $error("ready low");
  AST_OK: assert property (!hresp) else $error("resp");
  AST_STB: assert property (cw |-> ##2 strobe_n == !$past(hwdata[0])) else $error("stb");
  AST_AFD: assert property (cw |-> ##2 auto_linefeed_n == !$past(hwdata[1])) else $error("afd");
  AST_INI: assert property (cw |-> ##2 init_n == $past(hwdata[2])) else $error("init");
  AST_SEL: assert property (cw |-> ##2 peripheral_select_n == !$past(hwdata[3]))
    else $error("sel");
  AST_HOLD: assert property (!$stable({strobe_n, auto_linefeed_n, init_n, peripheral_select_n})
    |-> $past(cw, 2)) else $error("pin moved");
  AST_OE: assert property (!port_data_oe |-> port_data == 8'h00) else $error("oe");
endmodule : ppc_chk
bind ppc_port ppc_chk chk (.*);
`default_nettype wire

// ### sim/ppc_printer.sv
`timescale 1ns/1ns
`default_nettype none
module ppc_printer (
  input wire logic strobe_n, port_data_oe,
  input wire logic [7:0] port_data,
  input wire logic [4:0] st,
  output logic busy_in, ack_n, select_in, paper_error_in, fault_n,
  output logic [7:0] port_data_in, got
);
  // Status levels as the bench commands them
  assign {busy_in, ack_n, select_in, paper_error_in, fault_n} = st;
  // Released lines read inverted so stale data never looks valid
  assign port_data_in = port_data_oe ? port_data : ~port_data;
  // Forward data latched on the falling strobe
  always @(negedge strobe_n) got <= port_data;
endmodule : ppc_printer
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, clk_en = 1;
  logic [1:0] htrans = 0;
  logic [11:0] haddr = 0;
  logic [31:0] hwdata = 0, hrdata, rd, lf = 32'h9716;
  logic [4:0] st = 0;
  logic [7:0] port_data, port_data_in, got;
  logic hreadyout, hresp, strobe_n, auto_linefeed_n, init_n, peripheral_select_n, port_data_oe;
  logic busy_in, ack_n, select_in, paper_error_in, fault_n;
  int n_mismatch = 0, n_compared = 0;
  always #4 hclk = ~hclk;
  ppc_port dut (.hclk, .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .strobe_n, .auto_linefeed_n,
    .init_n, .peripheral_select_n, .port_data, .port_data_oe, .port_data_in, .busy_in, .ack_n,
    .select_in, .paper_error_in, .fault_n);
  ppc_printer prn (.strobe_n, .port_data_oe, .port_data, .st, .busy_in, .ack_n, .select_in,
    .paper_error_in, .fault_n, .port_data_in, .got);
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // One single transfer; waits on hready in both phases
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic end_sim;
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk("pins", 4'b1011, {peripheral_select_n, init_n, auto_linefeed_n, strobe_n});
    repeat (20) begin
      lf = lfsr(lf);
      st <= lf[12:8];
      xfer(1, 12'h000, lf);
      xfer(1, 12'h008, 0);
      xfer(1, 12'h008, 1);
      @(posedge hclk);
      chk("latch", lf[7:0], 32'(got));
      xfer(1, 12'h008, lf);
      @(posedge hclk);
      chk("pins", {~lf[3], lf[2], ~lf[1], ~lf[0]}, {peripheral_select_n, init_n,
        auto_linefeed_n, strobe_n});
      xfer(0, 12'h004, 0);
      chk("status", {~st[4], st[3], st[1], st[2], st[0], 3'h0}, rd);
    end
    // Frozen clock enable: a control write must not reach the pins
    clk_en <= 0;
    xfer(1, 12'h008, ~lf);
    @(posedge hclk);
    clk_en <= 1;
    @(posedge hclk);
    chk("frozen", {~lf[3], lf[2], ~lf[1], ~lf[0]}, {peripheral_select_n, init_n,
      auto_linefeed_n, strobe_n});
    // Direction bit only counts outside the first mode
    for (int m = 0; m < 4; m++) begin
      xfer(1, 12'h00C, m);
      xfer(1, 12'h008, 32'h0000_0020);
      xfer(0, 12'h000, 0);
      chk("data", m == 0 ? {24'h00_0000, lf[7:0]} : 32'h0000_00ff, rd);
      xfer(0, 12'h00C, 0);
      @(posedge hclk);
      chk("mode", m, rd);
      chk("oe", m == 0, port_data_oe);
    end
    xfer(1, 12'h00C, 0);
    xfer(0, 12'h010, 0);
    chk("unmapped", 0, rd);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
